// >>> aspc_pkg.sv
// Shared constants for the amplifier supply and protection controller.
package aspc_pkg;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_GAIN   = 8'h04;
  localparam logic [7:0] OFS_THRESH = 8'h08;
  localparam logic [7:0] OFS_FLASH  = 8'h0C;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_STAT1  = 8'h14;
  localparam logic [7:0] OFS_STAT3  = 8'h18;
  localparam logic [7:0] OFS_LIVE   = 8'h1C;

  // ****************************************************************
  // Control register fields.
  // ****************************************************************
  localparam int CTL_CLASSG    = 0;
  localparam int CTL_AUD_BOOST = 1;
  localparam int CTL_SMS_LO    = 2;
  localparam int CTL_HALVE     = 4;
  localparam int CTL_K1024     = 5;
  localparam int CTL_FLT_RLS   = 6;
  localparam int CTL_OVERHEAT_RELEASE   = 7;
  localparam int CTL_PDN       = 8;
  localparam int CTL_W         = 9;
  localparam logic [CTL_W-1:0] CTL_RESET = 9'h001;

  // ****************************************************************
  // Other register widths and reset values.
  // ****************************************************************
  localparam int GAIN_W = 2;
  localparam logic [GAIN_W-1:0] GAIN_DEFAULT = 2'h0;
  localparam int THR_W = 12;
  localparam logic [THR_W-1:0] THR_RESET = 12'h0_F0;
  localparam int FLS_W = 8;
  localparam logic [FLS_W-1:0] FLS_RESET = 8'h3F;
  localparam int SET_W = 4;

  // ****************************************************************
  // Flag and mask bit positions, shared by status and mask registers.
  // ****************************************************************
  localparam int FLG_FAULT  = 0;
  localparam int FLG_OTE    = 1;
  localparam int FLG_OTW    = 2;
  localparam int FLG_LOW_BATTERY_FLAG = 3;
  localparam int FLG_CURLIM = 4;
  localparam int FLG_W      = 5;
  localparam int STAT1_W    = 3;
  localparam logic [FLG_W-1:0] MASK_RESET = 5'h1F;
  localparam logic [FLG_W-1:0] STAT1_BITS = 5'h07;
  localparam logic [FLG_W-1:0] STAT3_BITS = 5'h18;

  // ****************************************************************
  // Supply rail codes, ordered from lowest to highest rail, then the LED supply mode select codes.
  // ****************************************************************
  localparam logic [1:0] RAIL_BYPASS = 2'h0;
  localparam logic [1:0] RAIL_LED    = 2'h1;
  localparam logic [1:0] RAIL_BOOST5 = 2'h2;
  localparam logic [1:0] SMS_LED     = 2'h0;
  localparam logic [1:0] SMS_BYPASS  = 2'h1;

  // ****************************************************************
  // Class G threshold arithmetic.
  // ****************************************************************
  localparam logic [12:0] BOOST_MV   = 13'h1388;
  localparam logic [10:0] K_ONE_MIL  = 11'h3E8;
  localparam logic [10:0] K_1024_MIL = 11'h400;
  localparam logic [13:0] THON_LMUL  = 14'h0BB8;
  localparam logic [2:0]  THON_RMUL  = 3'h2;
  localparam logic [13:0] THOFF_LMUL = 14'h3A98;
  localparam logic [2:0]  THOFF_RMUL = 3'h4;
  localparam logic [4:0]  GAIN_FRAC  = 5'h10;
  localparam logic [7:0]  GAIN_Q_9DB  = 8'h2D;
  localparam logic [7:0]  GAIN_Q_12DB = 8'h40;
  localparam logic [7:0]  GAIN_Q_15DB = 8'h5A;
  localparam logic [7:0]  GAIN_Q_18DB = 8'h7F;

  // ****************************************************************
  // Clock monitor timing.
  // ****************************************************************
  localparam int PCLK_PERIOD_PS = 8000;
  localparam int MCLK_STOP_NS   = 1000;
  localparam int MCLK_STOP_CYC  = (MCLK_STOP_NS * 1000) / PCLK_PERIOD_PS;
  localparam int STOP_W         = 8;
  localparam logic [1:0] BOOST_DIV_LAST = 2'h2;

endpackage

// >>> aspc_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module aspc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels in and out.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } aspc_sync_st_t;

  aspc_sync_st_t st_q;
  aspc_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;

endmodule
`default_nettype wire

// >>> aspc_clkmon.sv
// Master clock watchdog and boost switching rate generator.
`timescale 1ns/1ps
`default_nettype none
module aspc_clkmon
  import aspc_pkg::*;
(
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Synchronised master clock level and divide setting.
  input  wire logic mclk_sync,
  input  wire logic halve,
  // Results.
  output logic      tick_2mhz,
  output logic      clock_lost
);

  typedef struct packed {
    logic              prev;
    logic              phase;
    logic [1:0]        div;
    logic [STOP_W-1:0] stop;
    logic              lost;
    logic              tick;
  } aspc_clkmon_st_t;

  aspc_clkmon_st_t st_q;
  aspc_clkmon_st_t st_d;
  logic            rise;
  logic            int_tick;

  always_comb begin
    st_d     = st_q;
    rise     = mclk_sync & ~st_q.prev;
    int_tick = 1'b0;
    st_d.prev = mclk_sync;
    st_d.tick = 1'b0;
    if (rise) begin
      st_d.phase = ~st_q.phase;
      int_tick   = ~halve | st_q.phase;
    end
    if (int_tick) begin
      if (st_q.div == BOOST_DIV_LAST) begin
        st_d.div  = '0;
        st_d.tick = ~st_q.lost;
      end else begin
        st_d.div = st_q.div + 2'h1;
      end
    end
    // Each rising edge restarts the watchdog, so only a gap of more than 125 cycles between rising edges trips it.
    if (rise) begin
      st_d.stop = '0;
      st_d.lost = 1'b0;
    end else if (st_q.stop == STOP_W'(MCLK_STOP_CYC)) begin
      st_d.lost = 1'b1;
    end else begin
      st_d.stop = st_q.stop + STOP_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_2mhz  = st_q.tick;
  assign clock_lost = st_q.lost;

endmodule
`default_nettype wire

// >>> aspc_top.sv
// Supply selection, fault protection and host registers of the amplifier.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module aspc_top
  import aspc_pkg::*;
(
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Asynchronous status pins.
  input  wire logic              mclk_pin,
  input  wire logic              out_mismatch,
  input  wire logic              temp_warn,
  input  wire logic              temp_err,
  input  wire logic              vp_uvlo,
  input  wire logic              batt_below_th,
  input  wire logic              batt_above_recov,
  input  wire logic              curlim_hit,
  input  wire logic              flash_active,
  input  wire logic              flash_trigger_pin,
  input  wire logic              flash_inhibit_pin,
  input  wire logic              led_active,
  // Measurements from converters on pclk.
  input  wire logic [11:0]       audio_level_mv,
  input  wire logic [12:0]       battery_mv,
  // Interrupt to host, active low.
  output logic                   int_n,
  // Amplifier control.
  output logic                   amp_enable,
  output logic                   amp_hiz,
  output logic                   amp_clamp_gnd,
  output logic      [GAIN_W-1:0] amp_gain,
  // Boost converter control.
  output logic      [1:0]        rail_sel,
  output logic                   boost_switch,
  output logic      [SET_W-1:0]  inductor_peak_limit,
  // Battery and LED control.
  output logic      [SET_W-1:0]  low_battery_threshold,
  output logic      [SET_W-1:0]  battery_recovery_threshold,
  output logic      [SET_W-1:0]  flash_current,
  output logic                   led_enable,
  // Power domains.
  output logic                   analog_enable,
  output logic                   serial_port_pd
);

  // ****************************************************************
  // Input synchronisation and clock monitoring.
  // ****************************************************************
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] pins_s;
  logic             tick_2mhz;
  logic             clock_lost;

  aspc_sync #(.W(NSYNC)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({led_active, flash_inhibit_pin, flash_trigger_pin, flash_active,
                curlim_hit, batt_above_recov, batt_below_th, vp_uvlo,
                temp_err, temp_warn, out_mismatch, mclk_pin}),
    .sync_out (pins_s)
  );

  logic mclk_s, mism_s, twarn_s, terr_s;
  logic uvlo_s, below_s, recov_s, curlim_s;
  logic flash_s, trig_s, inh_s, led_s;
  assign {led_s, inh_s, trig_s, flash_s, curlim_s, recov_s, below_s, uvlo_s,
          terr_s, twarn_s, mism_s, mclk_s} = pins_s;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic [CTL_W-1:0]  ctrl;
    logic [GAIN_W-1:0] gain;
    logic [THR_W-1:0]  thr;
    logic [FLS_W-1:0]  fls;
    logic [FLG_W-1:0]  mask;
    logic [FLG_W-1:0]  flags;
    logic [FLG_W-1:0]  pend;
    logic [FLG_W-1:0]  cond_prev;
    logic              cg_boost;
    logic              short_latch;
    logic              ote_latch;
    logic              low_battery_flag_mode;
    logic              led_blocked;
    logic              trig_prev;
    logic              inh_prev;
    logic              int_n;
    logic              amp_enable;
    logic              amp_hiz;
    logic              amp_clamp;
    logic [1:0]        rail;
    logic              boost_sw;
    logic              analog_en;
    logic              sport_pd;
    logic              led_en;
    logic [SET_W-1:0]  flash_cur;
  } aspc_top_st_t;

  localparam aspc_top_st_t ST_RESET = '{
    ctrl: CTL_RESET, gain: GAIN_DEFAULT, thr: THR_RESET, fls: FLS_RESET,
    mask: MASK_RESET, int_n: 1'b1, rail: RAIL_BYPASS, sport_pd: 1'b1,
    default: '0};

  aspc_top_st_t st_q;
  aspc_top_st_t st_d;

  aspc_clkmon u_clkmon (
    .pclk       (pclk),
    .presetn    (presetn),
    .mclk_sync  (mclk_s),
    .halve      (st_q.ctrl[CTL_HALVE]),
    .tick_2mhz  (tick_2mhz),
    .clock_lost (clock_lost)
  );

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  // Both thresholds reduce to a cross-multiplied compare, so no divider is needed.
  function automatic logic level_exceeds(input logic [11:0] lvl,
                                         input logic [7:0]  gq,
                                         input logic [12:0] boosted_rail_mv,
                                         input logic [10:0] kmil,
                                         input logic [13:0] lmul,
                                         input logic [2:0]  rmul);
    logic [39:0] lhs;
    logic [39:0] rhs;
    lhs = 40'(lvl) * 40'(gq) * 40'(lmul);
    rhs = 40'(rmul) * 40'(kmil) * 40'(boosted_rail_mv) * 40'(GAIN_FRAC);
    return lhs > rhs;
  endfunction

  function automatic logic [7:0] gain_ratio(input logic [GAIN_W-1:0] idx);
    case (idx)
      2'h0:    return GAIN_Q_9DB;
      2'h1:    return GAIN_Q_12DB;
      2'h2:    return GAIN_Q_15DB;
      default: return GAIN_Q_18DB;
    endcase
  endfunction

  function automatic logic [1:0] rail_max(input logic [1:0] a, input logic [1:0] b);
    return (a > b) ? a : b;
  endfunction

  // ****************************************************************
  // Next state.
  // ****************************************************************
  logic             setup, access, wr, rd, hit;
  logic [31:0]      rdata;
  logic [FLG_W-1:0] cond;
  logic [FLG_W-1:0] rd_clr;
  logic [12:0]      boosted_rail_mv;
  logic [10:0]      kmil;
  logic             above_on, above_off, fault_hold, ote_hold, pdn;
  logic [1:0]       cg_rail;
  logic [1:0]       rail;
  logic             hiz;

  always_comb begin
    st_d   = st_q;
    setup  = psel & ~penable;
    access = psel & penable & st_q.pready;
    wr     = access & pwrite & ~st_q.pslverr;
    rd     = access & ~pwrite & ~st_q.pslverr;
    hit    = 1'b1;
    rdata  = '0;
    case (paddr)
      OFS_CTRL:   rdata = 32'(st_q.ctrl);
      OFS_GAIN:   rdata = 32'(st_q.gain);
      OFS_THRESH: rdata = 32'(st_q.thr);
      OFS_FLASH:  rdata = 32'(st_q.fls);
      OFS_MASK:   rdata = 32'(st_q.mask);
      OFS_STAT1:  rdata = 32'(st_q.flags[STAT1_W-1:0]);
      OFS_STAT3:  rdata = 32'(st_q.flags[FLG_W-1:STAT1_W]);
      OFS_LIVE:   rdata = 32'({st_q.led_blocked, st_q.low_battery_flag_mode, st_q.rail,
                               clock_lost, uvlo_s, st_q.amp_hiz});
      default:    hit = 1'b0;
    endcase

    // A bus transfer is answered in its first access cycle.
    st_d.pready  = setup;
    st_d.pslverr = setup & ~hit;
    if (setup) begin
      st_d.prdata = pwrite ? '0 : rdata;
    end
    if (wr) begin
      case (paddr)
        OFS_CTRL:   st_d.ctrl = pwdata[CTL_W-1:0];
        OFS_GAIN:   st_d.gain = pwdata[GAIN_W-1:0];
        OFS_THRESH: st_d.thr  = pwdata[THR_W-1:0];
        OFS_FLASH:  st_d.fls  = pwdata[FLS_W-1:0];
        OFS_MASK:   st_d.mask = pwdata[FLG_W-1:0];
        default:    st_d.thr  = st_q.thr;
      endcase
    end
    pdn = st_q.ctrl[CTL_PDN];
    if (uvlo_s) begin
      st_d.gain = GAIN_DEFAULT;
    end

    // Release works on the one-to-zero edge of its bit, and only once the cause is gone.
    fault_hold = st_q.ctrl[CTL_FLT_RLS] & ~st_d.ctrl[CTL_FLT_RLS];
    ote_hold   = st_q.ctrl[CTL_OVERHEAT_RELEASE] & ~st_d.ctrl[CTL_OVERHEAT_RELEASE];
    if (mism_s) begin
      st_d.short_latch = 1'b1;
    end else if (fault_hold) begin
      st_d.short_latch = 1'b0;
    end
    if (terr_s) begin
      st_d.ote_latch = 1'b1;
    end else if (ote_hold) begin
      st_d.ote_latch = 1'b0;
    end

    // Low battery mode starts only inside a flash and ends at the recovery level.
    if (!st_q.low_battery_flag_mode && below_s && flash_s) begin
      st_d.low_battery_flag_mode = 1'b1;
    end else if (st_q.low_battery_flag_mode && recov_s) begin
      st_d.low_battery_flag_mode = 1'b0;
    end
    st_d.flash_cur = (st_q.low_battery_flag_mode | inh_s) ? st_q.fls[FLS_W-1:SET_W]
                                                : st_q.fls[SET_W-1:0];

    // Sticky flags: a set in the cycle of a clearing read wins over the clear.
    cond = '0;
    cond[FLG_FAULT]  = mism_s;
    cond[FLG_OTE]    = terr_s;
    cond[FLG_OTW]    = twarn_s;
    cond[FLG_LOW_BATTERY_FLAG] = st_q.low_battery_flag_mode;
    cond[FLG_CURLIM] = curlim_s;
    rd_clr = '0;
    if (rd && paddr == OFS_STAT1) begin
      rd_clr = STAT1_BITS;
    end else if (rd && paddr == OFS_STAT3) begin
      rd_clr = STAT3_BITS;
    end
    st_d.cond_prev = cond;
    st_d.flags = (st_q.flags & ~(rd_clr & ~cond)) | cond;
    st_d.pend  = (st_q.pend & ~rd_clr) | (cond & ~st_q.cond_prev);
    st_d.int_n = ~|(st_d.pend & ~st_d.mask);

    // Class G decision with hysteresis between the two thresholds.
    boosted_rail_mv   = (st_q.rail == RAIL_BOOST5) ? BOOST_MV : battery_mv;
    kmil      = st_q.ctrl[CTL_K1024] ? K_1024_MIL : K_ONE_MIL;
    above_on  = level_exceeds(audio_level_mv, gain_ratio(st_q.gain), boosted_rail_mv, kmil,
                              THON_LMUL, THON_RMUL);
    above_off = level_exceeds(audio_level_mv, gain_ratio(st_q.gain), boosted_rail_mv, kmil,
                              THOFF_LMUL, THOFF_RMUL);
    if (above_on) begin
      st_d.cg_boost = 1'b1;
    end else if (!above_off) begin
      st_d.cg_boost = 1'b0;
    end
    cg_rail = st_q.cg_boost ? RAIL_BOOST5 : RAIL_BYPASS;

    // Supply rail selection; protective bypass overrides every mode.
    if (st_q.ote_latch || clock_lost || uvlo_s || pdn) begin
      rail = RAIL_BYPASS;
    end else if (st_q.ctrl[CTL_CLASSG]) begin
      rail = led_s ? rail_max(cg_rail, RAIL_LED) : cg_rail;
    end else if (led_s) begin
      case (st_q.ctrl[CTL_SMS_LO +: 2])
        SMS_LED:    rail = RAIL_LED;
        SMS_BYPASS: rail = RAIL_BYPASS;
        default:    rail = RAIL_BOOST5;
      endcase
    end else begin
      rail = st_q.ctrl[CTL_AUD_BOOST] ? RAIL_BOOST5 : RAIL_BYPASS;
    end
    st_d.rail     = rail;
    st_d.boost_sw = tick_2mhz & (rail != RAIL_BYPASS);

    // Amplifier: a stopped clock clamps, a fault or lockout floats the outputs.
    hiz             = st_q.short_latch | st_q.ote_latch | uvlo_s | pdn;
    st_d.amp_clamp  = clock_lost;
    st_d.amp_hiz    = hiz & ~clock_lost;
    st_d.amp_enable = ~hiz & ~clock_lost;

    // Analog and serial port power follow the lockout by themselves.
    st_d.analog_en = ~uvlo_s & ~pdn;
    st_d.sport_pd  = uvlo_s | pdn;

    // LEDs stay dark after an overheat until a new trigger or inhibit edge.
    st_d.trig_prev = trig_s;
    st_d.inh_prev  = inh_s;
    if (st_q.ote_latch) begin
      st_d.led_blocked = 1'b1;
    end else if ((trig_s & ~st_q.trig_prev) | (inh_s & ~st_q.inh_prev)) begin
      st_d.led_blocked = 1'b0;
    end
    st_d.led_en = ~st_q.ote_latch & ~st_q.led_blocked & ~uvlo_s & ~pdn
                  & ~clock_lost;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign prdata                     = st_q.prdata;
  assign pready                     = st_q.pready;
  assign pslverr                    = st_q.pslverr;
  assign int_n                      = st_q.int_n;
  assign amp_enable                 = st_q.amp_enable;
  assign amp_hiz                    = st_q.amp_hiz;
  assign amp_clamp_gnd              = st_q.amp_clamp;
  assign amp_gain                   = st_q.gain;
  assign rail_sel                   = st_q.rail;
  assign boost_switch               = st_q.boost_sw;
  assign inductor_peak_limit        = st_q.thr[THR_W-1:2*SET_W];
  assign low_battery_threshold      = st_q.thr[SET_W-1:0];
  assign battery_recovery_threshold = st_q.thr[2*SET_W-1:SET_W];
  assign flash_current              = st_q.flash_cur;
  assign led_enable                 = st_q.led_en;
  assign analog_enable              = st_q.analog_en;
  assign serial_port_pd             = st_q.sport_pd;

endmodule
`default_nettype wire

// >>> aspc_checker.sv
// Assertion checker for the supply controller top.
`timescale 1ns/1ps
`default_nettype none
module aspc_checker
  import aspc_pkg::*;
(
  input wire logic             pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0]       paddr,
  input wire logic             out_mismatch, temp_err, vp_uvlo, amp_hiz, amp_enable,
  input wire logic             amp_clamp_gnd, boost_switch, led_enable, analog_enable,
  input wire logic             serial_port_pd,
  input wire logic [1:0]       rail_sel,
  input wire logic [SET_W-1:0] inductor_peak_limit
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pin paths cross a synchroniser, so each response gets a few cycles.
  property p_fault; out_mismatch [*4] |-> ##[0:6] amp_hiz; endproperty
  a_fault: assert property (p_fault) else $error("fault no hiz");
  property p_heat; temp_err [*4] |-> ##[0:6] amp_hiz && rail_sel == RAIL_BYPASS; endproperty
  a_heat: assert property (p_heat) else $error("heat no safe");
  property p_led; temp_err [*4] |-> ##[0:6] !led_enable; endproperty
  a_led: assert property (p_led) else $error("heat led on");
  property p_uvlo; vp_uvlo [*4] |-> ##[0:6] serial_port_pd && !analog_enable; endproperty
  a_uvlo: assert property (p_uvlo) else $error("uvlo power");
  property p_ampoff; vp_uvlo [*4] |-> ##[0:6] !amp_enable; endproperty
  a_ampoff: assert property (p_ampoff) else $error("uvlo amp on");
  property p_clamp; amp_clamp_gnd [*3] |-> rail_sel == RAIL_BYPASS; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp boost");
  property p_pulse; boost_switch |=> !boost_switch; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_peak;
    $changed(inductor_peak_limit) |-> $past(psel && penable && pwrite && paddr == OFS_THRESH);
  endproperty
  a_peak: assert property (p_peak) else $error("peak changed");
  c_safe: cover property (amp_hiz && rail_sel == RAIL_BYPASS);
  c_clamp: cover property (amp_clamp_gnd);
  c_pulse: cover property (boost_switch);
endmodule
bind aspc_top aspc_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .out_mismatch(out_mismatch),
  .temp_err(temp_err), .vp_uvlo(vp_uvlo), .amp_hiz(amp_hiz), .amp_enable(amp_enable),
  .amp_clamp_gnd(amp_clamp_gnd), .boost_switch(boost_switch), .led_enable(led_enable),
  .analog_enable(analog_enable), .serial_port_pd(serial_port_pd), .rail_sel(rail_sel),
  .inductor_peak_limit(inductor_peak_limit));
`default_nettype wire

// >>> aspc_host.sv
// Host processor model: APB master and release sequencing.
`timescale 1ns/1ps
`default_nettype none
module aspc_host
  import aspc_pkg::*;
(
  input  wire logic        pclk,
  output logic             psel, penable, pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready, pslverr
);
  logic [31:0] ctrl = 32'(CTL_RESET);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    if (a == OFS_CTRL) ctrl = d;
    xfer(1'b1, a, d, r, e);
  endtask
  // The device acts on the falling write, so both halves are always sent.
  task automatic rls(input int b);
    wr(OFS_CTRL, ctrl | (32'h1 << b));
    wr(OFS_CTRL, ctrl & ~(32'h1 << b));
  endtask
endmodule
`default_nettype wire

// >>> aspc_top_tb_top.sv
// Self-checking testbench for the supply controller.
`timescale 1ns/1ps
`default_nettype none
module aspc_top_tb_top;
  import aspc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, int_n, mclk_pin, run, er;
  logic amp_enable, amp_hiz, clamp, bsw, led_en, an_en, sp_pd;
  logic [1:0] gain, rail;
  logic [3:0] peak, fcur, lowth, recth;
  logic [11:0] lvl;
  logic [7:0] paddr;
  logic [10:0] pin;
  logic [31:0] pwdata, prdata, rd;
  int mismatches, check_count;
  aspc_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  aspc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mclk_pin(mclk_pin), .out_mismatch(pin[0]), .temp_warn(pin[1]),
    .temp_err(pin[2]), .vp_uvlo(pin[3]), .batt_below_th(pin[4]), .batt_above_recov(pin[5]),
    .curlim_hit(pin[6]), .flash_active(pin[7]), .flash_trigger_pin(pin[8]),
    .flash_inhibit_pin(pin[9]), .led_active(pin[10]), .audio_level_mv(lvl),
    .battery_mv(13'h0F00), .int_n(int_n), .amp_enable(amp_enable), .amp_hiz(amp_hiz),
    .amp_clamp_gnd(clamp), .amp_gain(gain), .rail_sel(rail), .boost_switch(bsw),
    .inductor_peak_limit(peak), .low_battery_threshold(lowth), .battery_recovery_threshold(recth),
    .flash_current(fcur), .led_enable(led_en), .analog_enable(an_en), .serial_port_pd(sp_pd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic t_regs;
    rdc(OFS_MASK, 32'(MASK_RESET));
    rdc(OFS_FLASH, 32'(FLS_RESET));
    rdc(8'h20, 32'h0);
    chk(32'(er), 32'h1);
    i_host.wr(OFS_THRESH, 32'h0000_05A3);
    wt(2);
    chk(32'({peak, recth, lowth}), 32'h0000_05A3);
  endtask
  task automatic t_fault;
    i_host.wr(OFS_MASK, 32'h0000_0016);
    pin[0] <= 1'b1;
    wt(8);
    chk(32'({amp_hiz, int_n}), 32'h2);
    rdc(OFS_STAT1, 32'h1);
    wt(2);
    chk(32'(int_n), 32'h1);
    pin[0] <= 1'b0;
    wt(8);
    rdc(OFS_STAT1, 32'h1);
    rdc(OFS_STAT1, 32'h0);
    chk(32'(amp_hiz), 32'h1);
    i_host.rls(CTL_FLT_RLS);
    wt(4);
    chk(32'(amp_hiz), 32'h0);
  endtask
  task automatic t_heat;
    i_host.wr(OFS_CTRL, 32'h2);
    pin[1] <= 1'b1;
    wt(8);
    chk(32'({int_n, rail}), {29'h0, 1'b1, RAIL_BOOST5});
    pin[2] <= 1'b1;
    wt(8);
    chk(32'({amp_hiz, rail, led_en}), 32'h8);
    pin[2] <= 1'b0;
    wt(8);
    rdc(OFS_STAT1, 32'h6);
    pin[1] <= 1'b0;
    wt(8);
    rdc(OFS_STAT1, 32'h4);
    rdc(OFS_STAT1, 32'h0);
    chk(32'(amp_hiz), 32'h1);
    i_host.rls(CTL_OVERHEAT_RELEASE);
    wt(4);
    chk(32'({amp_hiz, led_en}), 32'h0);
    pin[8] <= 1'b1;
    wt(5);
    chk(32'(led_en), 32'h1);
    pin[8] <= 1'b0;
  endtask
  task automatic t_uvlo;
    i_host.wr(OFS_GAIN, 32'h3);
    rdc(OFS_GAIN, 32'h3);
    pin[3] <= 1'b1;
    wt(8);
    chk(32'({sp_pd, an_en, amp_enable}), 32'h4);
    pin[3] <= 1'b0;
    wt(8);
    chk(32'({sp_pd, an_en, amp_enable, gain}), {27'h0, 3'b011, GAIN_DEFAULT});
  endtask
  task automatic t_low_battery_flag;
    i_host.wr(OFS_FLASH, 32'h52);
    pin[4] <= 1'b1;
    wt(8);
    chk(32'(fcur), 32'h2);
    pin[7] <= 1'b1;
    wt(8);
    chk(32'({int_n, fcur}), 32'h5);
    rdc(OFS_STAT3, 32'h1);
    pin[4] <= 1'b0;
    pin[5] <= 1'b1;
    pin[6] <= 1'b1;
    wt(8);
    chk(32'(fcur), 32'h2);
    pin[7] <= 1'b0;
    pin[5] <= 1'b0;
    pin[6] <= 1'b0;
    wt(4);
    rdc(OFS_STAT3, 32'h3);
    rdc(OFS_STAT3, 32'h0);
  endtask
  task automatic t_supply;
    int n;
    i_host.wr(OFS_CTRL, 32'h2);
    wt(4);
    chk(32'(rail), 32'(RAIL_BOOST5));
    pin[10] <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      i_host.wr(OFS_CTRL, 32'(i) << 2);
      wt(8);
      chk(32'(rail), i == 0 ? 32'(RAIL_LED) : 32'(i * 2 - 2));
    end
    i_host.wr(OFS_CTRL, 32'h1);
    wt(8);
    chk(32'(rail), 32'(RAIL_LED));
    lvl <= 12'h400;
    wt(4);
    chk(32'(rail), 32'(RAIL_BOOST5));
    pin[10] <= 1'b0;
    lvl <= 12'h200;
    wt(8);
    chk(32'(rail), 32'(RAIL_BOOST5));
    lvl <= 12'h000;
    wt(4);
    chk(32'(rail), 32'(RAIL_BYPASS));
    i_host.wr(OFS_CTRL, 32'h2);
    run <= 1'b0;
    wt(140);
    chk(32'({clamp, rail}), 32'h4);
    run <= 1'b1;
    wt(12);
    chk(32'({clamp, rail}), 32'(RAIL_BOOST5));
    n = 0;
    repeat (60) begin
      @(posedge pclk);
      n += int'(bsw);
    end
    chk(32'(n), 32'hA);
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) mclk_pin <= run & ~mclk_pin;
  initial begin
    {presetn, mclk_pin, pin, lvl, mismatches, check_count} = '0;
    run = 1'b1;
    wt(5);
    presetn <= 1'b1;
    t_regs;
    t_fault;
    t_heat;
    t_uvlo;
    t_low_battery_flag;
    t_supply;
    test_done;
  end
  initial begin
    #100us;
    mismatches++;
    test_done;
  end
endmodule
`default_nettype wire
